// file: hw/pbc_pkg.sv
// Purpose: constants and register map of the per-generator blanking, chop and capture block
// Assumes: AHB-Lite register access, 125 MHz clock, one word per register
// Notes:   each generator owns four registers in a 16-byte window
//
// Contract
// - eight independent copies of blanking, chop and capture logic, one per generator
// - low-side-high enable blocks current-limit and fault while low side is high
// - low-side-low enable blocks current-limit and fault while low side is low
// - nine-bit blanking delay at bits 11:3, counts in 8.32 ns steps
// - period fine-resolution disable at bit 15 turns fine period off
// - duty fine-resolution disable at bit 14 turns fine duty off
// - state-blank select 0 none, 1..8 generator high side, 9 and up reserved
// - selected state-blank signal blocks only when its high or low enable set
// - chop select 0 internal chop clock, 1..8 generator high side, 9 reserved
// - selected chop source alternately enables and disables chop-enabled outputs
// - high-side chop enable at bit 1 chops the high-side output
// - low-side chop enable at bit 0 chops the low-side output
// - current-limit leading edge loads 13-bit time base into capture bits 15:3
// - capture exists only for the primary high-side output
// - capture uses current-limit after blanking, edges inside blanking ignored
// - capture resolution no finer than 8.32 ns
// - unimplemented bits read zero, writes to them have no effect
// - enabled high or low side rise or fall edges start blanking counter
// - leading-edge blanking applies per input only when its enable bit set
// - selected state-blank high or low blocks inputs when its enable set
// - high-side high or low blocks inputs when its enable set
package pbc_pkg;
    localparam int          NUM_GEN      = 8;
    localparam int          SEL_W        = 4;
    localparam int          TB_W         = 13;
    localparam int          LEB_W        = 9;
    // register word offsets inside a generator window
    localparam logic [1:0]  REG_CTL      = 2'h0;
    localparam logic [1:0]  REG_DLY      = 2'h1;
    localparam logic [1:0]  REG_AUX      = 2'h2;
    localparam logic [1:0]  REG_CAP      = 2'h3;
    // implemented-bit masks
    localparam logic [15:0] CTL_MASK     = 16'hFC3F;
    localparam logic [15:0] DLY_MASK     = 16'h0FF8;
    localparam logic [15:0] AUX_MASK     = 16'hCF3F;
    localparam logic [15:0] RST_VAL      = 16'h0000;
    // control field positions
    localparam int          C_PHR = 15, C_PHF = 14, C_PLR = 13, C_PLF = 12;
    localparam int          C_FLTEN = 11, C_CLEN = 10, C_BCH = 5, C_BCL = 4;
    localparam int          C_BLANK_ON_HIGH_SIDE_HIGH = 3, C_BLANK_ON_HIGH_SIDE_LOW = 2, C_BLANK_ON_LOW_SIDE_HIGH = 1, C_BLANK_ON_LOW_SIDE_LOW = 0;
    localparam int          D_LSB = 3, D_MSB = 11;
    localparam int          A_HRP = 15, A_HRD = 14, A_BS_LSB = 8, A_CS_LSB = 2;
    localparam int          A_CHH = 1, A_CHL = 0;
    localparam int          CAP_LSB = 3;
    localparam logic [3:0]  SEL_NONE     = 4'h0;
    localparam logic [3:0]  SEL_MAX      = 4'h8;
    // one delay step equals one time base tick of 8.32 ns, here 1 clk (8 ns, rounded down)
    localparam real         STEP_NS      = 8.32;
    localparam real         CLK_NS       = 8.0;
    localparam int          STEP_CYC     = (int'(STEP_NS / CLK_NS) < 1) ? 1 : int'(STEP_NS / CLK_NS);
    localparam logic [1:0]  HTRANS_NSEQ  = 2'h2;
endpackage : pbc_pkg

// file: hw/pbc_top.sv
// Purpose: eight generators' blanking, chop and capture logic behind an AHB-Lite slave
// Assumes: PWM outputs, fault, current limit and time bases synchronous to clk
// Notes:   one-cycle wait-free slave, OKAY always; upper address bits ignored, so every word aliases a register
`timescale 1ns/1ps
module pbc_top
    import pbc_pkg::*;
(
    input  wire logic                          clk,
    input  wire logic                          sys_rst,
    input  wire logic                          hsel,
    input  wire logic [31:0]                   haddr,
    input  wire logic [1:0]                    htrans,
    input  wire logic                          hwrite,
    input  wire logic [2:0]                    hsize,
    input  wire logic [31:0]                   hwdata,
    input  wire logic                          hready,
    output logic [31:0]                        hrdata,
    output logic                               hreadyout,
    output logic                               hresp,
    input  wire logic [pbc_pkg::NUM_GEN-1:0]   highSideIn,
    input  wire logic [pbc_pkg::NUM_GEN-1:0]   lowSideIn,
    input  wire logic [pbc_pkg::NUM_GEN-1:0]   faultIn,
    input  wire logic [pbc_pkg::NUM_GEN-1:0]   currentLimitIn,
    input  wire logic                          chopClkIn,
    input  wire logic [pbc_pkg::NUM_GEN*pbc_pkg::TB_W-1:0] timeBaseIn,
    output logic [pbc_pkg::NUM_GEN-1:0]        highSideOut,
    output logic [pbc_pkg::NUM_GEN-1:0]        lowSideOut,
    output logic [pbc_pkg::NUM_GEN-1:0]        faultBlanked,
    output logic [pbc_pkg::NUM_GEN-1:0]        currentLimitBlanked,
    output logic [pbc_pkg::NUM_GEN-1:0]        finePeriodDisable,
    output logic [pbc_pkg::NUM_GEN-1:0]        fineDutyDisable
);
    import pbc_pkg::*;

    typedef struct packed {
        logic                 wrPend;
        logic [2:0]           wrGen;
        logic [1:0]           wrReg;
        logic [31:0]          rdData;
        logic [NUM_GEN-1:0][15:0] ctl;
        logic [NUM_GEN-1:0][15:0] dly;
        logic [NUM_GEN-1:0][15:0] aux;
        logic [NUM_GEN-1:0][TB_W-1:0] cap;
        logic [NUM_GEN-1:0][LEB_W-1:0] lebCnt;
        logic [NUM_GEN-1:0]   hPrev;
        logic [NUM_GEN-1:0]   lPrev;
        logic [NUM_GEN-1:0]   clPrev;
        logic [NUM_GEN-1:0]   hOut;
        logic [NUM_GEN-1:0]   lOut;
        logic [NUM_GEN-1:0]   fltOut;
        logic [NUM_GEN-1:0]   clOut;
    } pbc_state_type;

    pbc_state_type st_r;
    pbc_state_type st_nxt;

    logic [NUM_GEN-1:0] blkFlt;
    logic [NUM_GEN-1:0] blkCl;
    logic [NUM_GEN-1:0] clMasked;

    // address phase of a valid transfer
    logic       addrOk;
    logic [2:0] aGen;
    logic [1:0] aReg;
    assign addrOk = hsel && hready && htrans == HTRANS_NSEQ;
    assign aGen   = haddr[6:4];
    assign aReg   = haddr[3:2];

    // slave never waits and never errors
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = st_r.rdData;

    // next-state of the whole block
    always_comb begin
        logic [15:0]    rv;
        logic [3:0]     bsel;
        logic [3:0]     csel;
        logic           srcSig;
        logic           chopSig;
        logic           stateBlk;
        logic           edgeHit;
        logic           lebRun;
        logic [TB_W-1:0] tb;
        rv      = RST_VAL;
        bsel    = SEL_NONE;
        csel    = SEL_NONE;
        srcSig  = 1'b0;
        chopSig = 1'b0;
        stateBlk = 1'b0;
        edgeHit = 1'b0;
        lebRun  = 1'b0;
        tb      = '0;
        st_nxt  = st_r;
        blkFlt  = '0;
        blkCl   = '0;
        clMasked = '0;
        st_nxt.wrPend = addrOk && hwrite;
        st_nxt.wrGen  = aGen;
        st_nxt.wrReg  = aReg;
        if (st_r.wrPend) begin
            case (st_r.wrReg)
                REG_CTL: st_nxt.ctl[st_r.wrGen] = hwdata[15:0] & CTL_MASK;
                REG_DLY: st_nxt.dly[st_r.wrGen] = hwdata[15:0] & DLY_MASK;
                REG_AUX: st_nxt.aux[st_r.wrGen] = hwdata[15:0] & AUX_MASK;
                default: ;
            endcase
        end
        if (addrOk && !hwrite) begin
            case (aReg)
                REG_CTL: rv = st_r.ctl[aGen];
                REG_DLY: rv = st_r.dly[aGen];
                REG_AUX: rv = st_r.aux[aGen];
                default: rv = {st_r.cap[aGen], 3'h0};
            endcase
            st_nxt.rdData = {16'h0000, rv};
        end
        for (int g = 0; g < NUM_GEN; g++) begin
            bsel = st_r.aux[g][A_BS_LSB +: SEL_W];
            csel = st_r.aux[g][A_CS_LSB +: SEL_W];
            // state-blank source decode, reserved acts as none
            srcSig = (bsel != SEL_NONE && bsel <= SEL_MAX) ? highSideIn[3'(bsel - 4'h1)]
                                                          : 1'b0;
            stateBlk = (bsel != SEL_NONE && bsel <= SEL_MAX) &&
                       ((st_r.ctl[g][C_BCH] && srcSig) || (st_r.ctl[g][C_BCL] && !srcSig));
            stateBlk = stateBlk || (st_r.ctl[g][C_BLANK_ON_HIGH_SIDE_HIGH] && highSideIn[g])
                                || (st_r.ctl[g][C_BLANK_ON_HIGH_SIDE_LOW] && !highSideIn[g]);
            stateBlk = stateBlk || (st_r.ctl[g][C_BLANK_ON_LOW_SIDE_HIGH] && lowSideIn[g])
                                || (st_r.ctl[g][C_BLANK_ON_LOW_SIDE_LOW] && !lowSideIn[g]);
            edgeHit = (st_r.ctl[g][C_PHR] && highSideIn[g] && !st_r.hPrev[g])
                   || (st_r.ctl[g][C_PHF] && !highSideIn[g] && st_r.hPrev[g])
                   || (st_r.ctl[g][C_PLR] && lowSideIn[g] && !st_r.lPrev[g])
                   || (st_r.ctl[g][C_PLF] && !lowSideIn[g] && st_r.lPrev[g]);
            // delay in 8.32 ns steps, one step per clk
            // the edge cycle is itself the first blocked step, so load one less
            if (edgeHit && st_r.dly[g][D_MSB:D_LSB] != '0)
                st_nxt.lebCnt[g] = st_r.dly[g][D_MSB:D_LSB] - 9'h001;
            else if (edgeHit)
                st_nxt.lebCnt[g] = '0;
            else if (st_r.lebCnt[g] != '0)
                st_nxt.lebCnt[g] = st_r.lebCnt[g] - 9'h001;
            lebRun = edgeHit ? (st_r.dly[g][D_MSB:D_LSB] != '0) : (st_r.lebCnt[g] != '0);
            blkFlt[g]   = stateBlk || (lebRun && st_r.ctl[g][C_FLTEN]);
            blkCl[g]    = stateBlk || (lebRun && st_r.ctl[g][C_CLEN]);
            clMasked[g] = currentLimitIn[g] && !blkCl[g];
            st_nxt.fltOut[g] = faultIn[g] && !blkFlt[g];
            st_nxt.clOut[g]  = clMasked[g];
            // chop source decode, reserved gives no chop clock
            chopSig = (csel == SEL_NONE) ? chopClkIn :
                      (csel <= SEL_MAX)  ? highSideIn[3'(csel - 4'h1)] : 1'b0;
            st_nxt.hOut[g] = highSideIn[g] && (!st_r.aux[g][A_CHH] || chopSig);
            st_nxt.lOut[g] = lowSideIn[g] && (!st_r.aux[g][A_CHL] || chopSig);
            tb = timeBaseIn[g*TB_W +: TB_W];
            if (clMasked[g] && !st_r.clPrev[g])
                st_nxt.cap[g] = tb;
            st_nxt.hPrev[g]  = highSideIn[g];
            st_nxt.lPrev[g]  = lowSideIn[g];
            st_nxt.clPrev[g] = clMasked[g];
        end
    end

    // single state register; reset clears everything
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // outputs from flip-flops
    assign highSideOut         = st_r.hOut;
    assign lowSideOut          = st_r.lOut;
    assign faultBlanked        = st_r.fltOut;
    assign currentLimitBlanked = st_r.clOut;
    for (genvar g = 0; g < NUM_GEN; g++) begin : g_hr
        assign finePeriodDisable[g] = st_r.aux[g][A_HRP];
        assign fineDutyDisable[g]   = st_r.aux[g][A_HRD];
    end

    // assertions
    ctl_mask_a: assert property (@(posedge clk) disable iff (sys_rst)
        (st_r.ctl[0] & ~CTL_MASK) == 16'h0000 && (st_r.aux[0] & ~AUX_MASK) == 16'h0000)
        else $error("unimplemented control bits set");
    dly_mask_a: assert property (@(posedge clk) disable iff (sys_rst)
        (st_r.dly[0] & ~DLY_MASK) == 16'h0000) else $error("delay reserved bits set");
    lowhigh_blk_a: assert property (@(posedge clk) disable iff (sys_rst)
        st_r.ctl[0][C_BLANK_ON_LOW_SIDE_HIGH] && lowSideIn[0] |=> !faultBlanked[0])
        else $error("fault passed while low side high blanked");
    lowlow_blk_a: assert property (@(posedge clk) disable iff (sys_rst)
        st_r.ctl[0][C_BLANK_ON_LOW_SIDE_LOW] && !lowSideIn[0] |=> !currentLimitBlanked[0])
        else $error("current limit passed while low side low blanked");
    no_blank_a: assert property (@(posedge clk) disable iff (sys_rst)
        st_r.ctl[0] == 16'h0000 |=> faultBlanked[0] == $past(faultIn[0]))
        else $error("fault blocked without any blanking");
    chop_off_a: assert property (@(posedge clk) disable iff (sys_rst)
        !st_r.aux[0][A_CHH] |=> highSideOut[0] == $past(highSideIn[0]))
        else $error("high side altered while chop off");
    chop_low_a: assert property (@(posedge clk) disable iff (sys_rst)
        st_r.aux[0][A_CHL] && st_r.aux[0][A_CS_LSB +: SEL_W] == SEL_NONE && !chopClkIn
        |=> !lowSideOut[0]) else $error("low side not chopped");
    cap_load_a: assert property (@(posedge clk) disable iff (sys_rst)
        clMasked[0] && !st_r.clPrev[0] |=> st_r.cap[0] == $past(timeBaseIn[TB_W-1:0]))
        else $error("capture not loaded");
    cap_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
        blkCl[0] |=> $stable(st_r.cap[0])) else $error("capture inside blanking");
    hr_bit_a: assert property (@(posedge clk) disable iff (sys_rst)
        finePeriodDisable[0] == st_r.aux[0][A_HRP] && fineDutyDisable[0] == st_r.aux[0][A_HRD])
        else $error("fine disable mismatch");
    // high-side level blanking, both polarities
    hi_side_blk_a: assert property (@(posedge clk) disable iff (sys_rst)
        st_r.ctl[0][C_BLANK_ON_HIGH_SIDE_HIGH] && highSideIn[0] |=> !faultBlanked[0] && !currentLimitBlanked[0])
        else $error("input passed while high side high blanked");
    hi_low_blk_a: assert property (@(posedge clk) disable iff (sys_rst)
        st_r.ctl[0][C_BLANK_ON_HIGH_SIDE_LOW] && !highSideIn[0] |=> !faultBlanked[0] && !currentLimitBlanked[0])
        else $error("input passed while high side low blanked");

    // selected source blanking; the reserved and none checks set only a source enable, so nothing else blocks
    src_high_blk_a: assert property (@(posedge clk) disable iff (sys_rst)
        st_r.aux[0][A_BS_LSB +: SEL_W] == 4'h2 && st_r.ctl[0][C_BCH] && highSideIn[1]
        |=> !currentLimitBlanked[0]) else $error("input passed while source high blanked");
    src_rsvd_a: assert property (@(posedge clk) disable iff (sys_rst)
        (st_r.ctl[0] == (16'h0001 << C_BCH) || st_r.ctl[0] == (16'h0001 << C_BCL)) &&
        st_r.aux[0][A_BS_LSB +: SEL_W] > SEL_MAX |=> faultBlanked[0] == $past(faultIn[0]))
        else $error("reserved source blanked");
    src_none_a: assert property (@(posedge clk) disable iff (sys_rst)
        (st_r.ctl[0] == (16'h0001 << C_BCH) || st_r.ctl[0] == (16'h0001 << C_BCL)) &&
        st_r.aux[0][A_BS_LSB +: SEL_W] == SEL_NONE |=> faultBlanked[0] == $past(faultIn[0]))
        else $error("no source selected but blanked");

    // chop source decode on generator 1, where the bench exercises it
    chop_int_a: assert property (@(posedge clk) disable iff (sys_rst)
        st_r.aux[1][A_CHH] && st_r.aux[1][A_CS_LSB +: SEL_W] == SEL_NONE
        |=> highSideOut[1] == $past(highSideIn[1] && chopClkIn))
        else $error("high side not chopped by internal clock");
    chop_pin_a: assert property (@(posedge clk) disable iff (sys_rst)
        st_r.aux[1][A_CHH] && st_r.aux[1][A_CS_LSB +: SEL_W] == 4'h1
        |=> highSideOut[1] == $past(highSideIn[1] && highSideIn[0]))
        else $error("high side not chopped by first generator");
    chop_rsvd_a: assert property (@(posedge clk) disable iff (sys_rst)
        st_r.aux[1][A_CHL] && st_r.aux[1][A_CS_LSB +: SEL_W] > SEL_MAX |=> !lowSideOut[1])
        else $error("reserved chop source let low side through");

    // delay counter start and effect
    leb_load_a: assert property (@(posedge clk) disable iff (sys_rst)
        st_r.ctl[0][C_PHR] && highSideIn[0] && !st_r.hPrev[0] &&
        st_r.dly[0][D_MSB:D_LSB] != '0
        |=> st_r.lebCnt[0] == $past(st_r.dly[0][D_MSB:D_LSB] - 9'h001))
        else $error("blanking counter not loaded on enabled edge");
    leb_fault_a: assert property (@(posedge clk) disable iff (sys_rst)
        st_r.lebCnt[0] != '0 && st_r.dly[0][D_MSB:D_LSB] != '0 && st_r.ctl[0][C_FLTEN]
        |=> !faultBlanked[0]) else $error("fault passed during blanking delay");
    leb_off_a: assert property (@(posedge clk) disable iff (sys_rst)
        (st_r.ctl[0] & ~16'hF400) == 16'h0000 |=> faultBlanked[0] == $past(faultIn[0]))
        else $error("fault blanked with its enable clear");

    // upper half of every read word is unimplemented
    rd_zero_a: assert property (@(posedge clk) disable iff (sys_rst)
        hrdata[31:16] == 16'h0000) else $error("upper read bits not zero");

    // every generator keeps its own masked control and delay registers and low-side-high blanking
    for (genvar g = 0; g < NUM_GEN; g++) begin : g_chk
        gen_mask_a: assert property (@(posedge clk) disable iff (sys_rst)
            (st_r.dly[g] & ~DLY_MASK) == 16'h0000 && (st_r.ctl[g] & ~CTL_MASK) == 16'h0000)
            else $error("generator register holds unimplemented bits");
        gen_blk_a: assert property (@(posedge clk) disable iff (sys_rst)
            st_r.ctl[g][C_BLANK_ON_LOW_SIDE_HIGH] && lowSideIn[g] |=> !currentLimitBlanked[g])
            else $error("generator passed current limit while low side high");
    end

    cov_src_blank: cover property (@(posedge clk) disable iff (sys_rst)
        st_r.ctl[0][C_BCH] && st_r.aux[0][A_BS_LSB +: SEL_W] != SEL_NONE && !faultBlanked[0]);
    cov_chop_pin: cover property (@(posedge clk) disable iff (sys_rst)
        st_r.aux[1][A_CHH] && st_r.aux[1][A_CS_LSB +: SEL_W] != SEL_NONE && !highSideOut[1]);
    cov_capture: cover property (@(posedge clk) disable iff (sys_rst)
        clMasked[0] && !st_r.clPrev[0]);
    cov_leb_run: cover property (@(posedge clk) disable iff (sys_rst)
        st_r.lebCnt[0] != '0 ##1 st_r.lebCnt[0] == '0);
    cov_chop: cover property (@(posedge clk) disable iff (sys_rst)
        st_r.aux[0][A_CHH] && highSideIn[0] && !highSideOut[0]);
endmodule : pbc_top

// file: verif/pbc_top_bench.sv
// Purpose: self-checking bench for the blanking, chop and capture block
// Assumes: one AHB-Lite master, word transfers only, raw pins driven after rising edges
// Notes:   outputs are sampled on the falling edge, after two rising edges in settle and every cycle in edgeCount
`timescale 1ns/1ps
module pbc_top_bench;
    import pbc_pkg::*;
    logic         clk = 1'b0, sys_rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, chopClkIn = 1'b0;
    logic [31:0]  haddr = 32'h0, hwdata = 32'h0, hrdata;
    logic [1:0]   htrans = 2'h0;
    logic [2:0]   hsize = 3'h2;
    logic         hreadyout, hresp;
    logic [7:0]   highSideIn = 8'h00, lowSideIn = 8'h00, faultIn = 8'h00, currentLimitIn = 8'h00;
    logic [103:0] timeBaseIn = 104'h0;
    logic [7:0]   highSideOut, lowSideOut, faultBlanked, currentLimitBlanked;
    logic [7:0]   finePeriodDisable, fineDutyDisable;
    logic [15:0]  msk [4] = '{CTL_MASK, DLY_MASK, AUX_MASK, 16'h0000};
    int           nErrors = 0, nCompared = 0;

    // 125 MHz clock
    always #4 clk = ~clk;

    pbc_top uut (.clk(clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .highSideIn(highSideIn), .lowSideIn(lowSideIn),
        .faultIn(faultIn), .currentLimitIn(currentLimitIn), .chopClkIn(chopClkIn),
        .timeBaseIn(timeBaseIn), .highSideOut(highSideOut), .lowSideOut(lowSideOut),
        .faultBlanked(faultBlanked), .currentLimitBlanked(currentLimitBlanked),
        .finePeriodDisable(finePeriodDisable), .fineDutyDisable(fineDutyDisable));

    task automatic closeOut();
        $display("compared %0d, errors %0d", nCompared, nErrors);
        if (nErrors == 0 && nCompared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : closeOut

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        nCompared++;
        if (got !== exp) begin
            nErrors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    // bounded wait, a stuck slave ends the run rather than hanging it
    task automatic waitReady();
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (hreadyout !== 1'b1 && n < 64);
        if (hreadyout !== 1'b1) begin
            nErrors++;
            closeOut();
        end
    endtask : waitReady

    task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] wd,
                        output logic [31:0] rd);
        @(posedge clk);
        hsel   <= 1'b1;
        haddr  <= a;
        htrans <= HTRANS_NSEQ;
        hwrite <= wr;
        waitReady();
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        waitReady();
        rd = hrdata;
    endtask : xfer

    task automatic wr(input int g, input int r, input logic [31:0] v);
        logic [31:0] d;
        xfer(1'b1, 32'(g * 16 + r * 4), v, d);
    endtask : wr

    task automatic chk(input int g, input int r, input logic [31:0] e);
        logic [31:0] d;
        xfer(1'b0, 32'(g * 16 + r * 4), 32'h0, d);
        check(d, e);
        check(32'(hresp), 32'h0);
    endtask : chk

    task automatic pins(input logic [7:0] hs, ls, fl, cl, input logic ch, input logic [12:0] tb);
        @(posedge clk);
        highSideIn     <= hs;
        lowSideIn      <= ls;
        faultIn        <= fl;
        currentLimitIn <= cl;
        chopClkIn      <= ch;
        timeBaseIn     <= {91'h0, tb};
    endtask : pins

    task automatic settle();
        repeat (2) @(posedge clk);
        @(negedge clk);
    endtask : settle

    // counts blocked cycles of generator 0 after one pin change
    task automatic edgeCount(input logic [7:0] hs, ls, output int zc, output int zf);
        pins(hs, ls, 8'hFF, 8'hFF, 1'b0, 13'h0);
        zc = 0;
        zf = 0;
        repeat (24) begin
            @(negedge clk);
            if (currentLimitBlanked[0] !== 1'b1) zc++;
            if (faultBlanked[0] !== 1'b1) zf++;
        end
    endtask : edgeCount

    initial begin
        logic [15:0] v;
        logic [7:0]  p, fpExp, fdExp;
        logic        sel, lvl, blk, src;
        int          zc, zf;
        repeat (5) @(posedge clk);
        sys_rst <= 1'b0;
        for (int g = 0; g < NUM_GEN; g++) begin
            for (int r = 0; r < 4; r++) chk(g, r, 32'h0);
            wr(g, REG_CTL, {16'hFFFF, ~(16'(g) * 16'h1111)});
            wr(g, REG_DLY, {16'hFFFF, ~(16'(g) * 16'h1111)});
            wr(g, REG_AUX, {16'hFFFF, ~(16'(g) * 16'h1111)});
            wr(g, REG_CAP, 32'hFFFF_FFFF);
        end
        for (int g = 0; g < NUM_GEN; g++) begin
            v = ~(16'(g) * 16'h1111);
            fpExp[g] = v[A_HRP];
            fdExp[g] = v[A_HRD];
            for (int r = 0; r < 4; r++) chk(g, r, {16'h0, v & msk[r]});
        end
        settle();
        check({finePeriodDisable, fineDutyDisable}, {fpExp, fdExp});
        // upper address bits are not decoded, so this aliases generator 0
        chk(16, REG_DLY, {16'h0, DLY_MASK});
        wr(0, REG_AUX, 32'h0);
        wr(0, REG_DLY, 32'h0);
        for (int b = 0; b < 4; b++) begin
            wr(0, REG_CTL, 32'h1 << b);
            for (int lv = 0; lv < 2; lv++) begin
                pins(lv ? 8'h00 : 8'hFF, lv ? 8'hFF : 8'h00, 8'hFF, 8'hFF, 1'b0, 13'h0);
                settle();
                blk = (b == 0 || b == 3) ^ (lv == 1);
                check({faultBlanked[0], currentLimitBlanked[0]}, blk ? 2'b00 : 2'b11);
            end
        end
        for (int m = 0; m < 2; m++) begin
            wr(0, REG_CTL, m ? (32'h1 << C_BCL) : (32'h1 << C_BCH));
            for (int k = 0; k < 10; k++) begin
                wr(0, REG_AUX, 32'(k) << A_BS_LSB);
                sel = (k >= 1 && k <= 8);
                for (int q = 0; q < 2; q++) begin
                    p = sel ? (8'h01 << (k - 1)) : 8'hFF;
                    p = q ? ~p : p;
                    pins(p, 8'h00, 8'hFF, 8'hFF, 1'b0, 13'h0);
                    settle();
                    lvl = sel ? p[k - 1] : 1'b0;
                    blk = sel && (m ? !lvl : lvl);
                    check({faultBlanked[0], currentLimitBlanked[0]}, blk ? 2'b00 : 2'b11);
                end
            end
        end
        // delay counter on enabled edges only
        wr(0, REG_AUX, 32'h0);
        wr(0, REG_CTL, (32'h1 << C_PHR) | (32'h1 << C_CLEN));
        wr(0, REG_DLY, 32'(5) << D_LSB);
        settle();
        edgeCount(8'h01, 8'h00, zc, zf);
        check({zc[15:0], zf[15:0]}, {16'h5, 16'h0});
        edgeCount(8'h00, 8'h00, zc, zf);
        check({zc[15:0], zf[15:0]}, 32'h0);
        wr(0, REG_CTL, (32'h1 << C_PLR) | (32'h1 << C_FLTEN));
        edgeCount(8'h00, 8'h01, zc, zf);
        check({zc[15:0], zf[15:0]}, {16'h0, 16'h5});
        // no external period reset exists here, so capture is always legal
        wr(0, REG_CTL, 32'h1 << C_CLEN);
        pins(8'h00, 8'h00, 8'h00, 8'h00, 1'b0, 13'h1ABC);
        pins(8'h00, 8'h00, 8'h00, 8'h01, 1'b0, 13'h1ABC);
        settle();
        chk(0, REG_CAP, 32'h0000_D5E0);
        // a pulse hidden by blanking leaves the capture alone
        wr(0, REG_CTL, (32'h1 << C_PHR) | (32'h1 << C_CLEN));
        wr(0, REG_DLY, 32'(20) << D_LSB);
        pins(8'h00, 8'h00, 8'h00, 8'h00, 1'b0, 13'h0123);
        pins(8'h01, 8'h00, 8'h00, 8'h00, 1'b0, 13'h0123);
        pins(8'h01, 8'h00, 8'h00, 8'h01, 1'b0, 13'h0123);
        pins(8'h01, 8'h00, 8'h00, 8'h00, 1'b0, 13'h0123);
        repeat (30) @(posedge clk);
        chk(0, REG_CAP, 32'h0000_D5E0);
        for (int m = 0; m < 2; m++) begin
            for (int s = 0; s < 10; s++) begin
                wr(1, REG_AUX, (32'(s) << A_CS_LSB) | (m ? 32'h1 : 32'h2));
                for (int c = 0; c < 2; c++) begin
                    p = c ? 8'hFF : 8'h02;
                    pins(p, 8'h02, 8'h00, 8'h00, c[0], 13'h0);
                    settle();
                    src = (s == 0) ? c[0] : ((s <= 8) ? p[s - 1] : 1'b0);
                    check({highSideOut[1], lowSideOut[1]}, m ? {1'b1, src} : {src, 1'b1});
                end
            end
        end
        closeOut();
    end
endmodule : pbc_top_bench
